// File: src/ext_memory_bus_sequencer.sv
// external memory bus sequencer with AHB-Lite control registers
//
// Behaviour
// RQ1 - upper 30 address bits driven on the shared bus only in T1 and T2; the code also drives them while idle and not granted
// RQ2 - 32-bit data: 30 on shared bus, bits 1 and 0 on flag pins
// RQ3 - read strobe low through T4, waits and T5; data caught at its rise
// RQ4 - write flag low in T1/T2 for writes, carries data bit 0 in T3-T6
// RQ5 - refresh flag low in T1/T2 for refresh, carries data bit 1 in T3-T6
// RQ6 - four active-low byte write strobes, strobe 0 for the lowest byte
// RQ7 - five general strobes, one fixed, four with configured timing
// RQ8 - wait input held high extends T4 by wait states
// RQ9 - async DMA request granted together with tristating the bus
// RQ10 - grant changes on falling processor clock edge only
// RQ11 - half-cycle unit is exactly half the processor clock period
// RQ12 - cycle T1-T4, waits, T5, T6; T1-T5 one to four, T6 one to five
// RQ13 - memory drives read data after T3, valid at end of T5
// RQ14 - strobe 0 falls at start of T2, rises at end of T5
// RQ15 - strobe 1 low from T2 for 0-31 half-cycles, never past T6
// RQ16 - strobe 1 length counted from its start, waits do not stretch it
// RQ17 - strobes 2-4 fall 1-31 half-cycles after T2, rise at end of T5
// RQ18 - refresh enabled or disabled by configuration with its interval
// RQ19 - refresh-due output high while a refresh cycle waits
// RQ20 - timing configuration read serially through the config pin
// RQ21 - six phases in order T1 to T6
// RQ22 - odd total adds one half-cycle so the next T1 starts rising
// RQ23 - after reset every phase is four half-cycles until configured
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
module ext_memory_bus_sequencer
  import ext_bus_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [29:0] shared_addr_data_bus_in,
  output logic [29:0] shared_addr_data_bus_out,
  output logic [29:0] shared_addr_data_bus_oe,
  input wire logic write_flag_data0_in,
  output logic write_flag_data0_out,
  output logic write_flag_data0_oe,
  input wire logic refresh_flag_data1_in,
  output logic refresh_flag_data1_out,
  output logic refresh_flag_data1_oe,
  output logic read_strobe_n,
  output logic [3:0] byte_write_strobes_n,
  output logic [4:0] general_strobes_n,
  output logic refresh_strobe_n,
  output logic refresh_due,
  input wire logic wait_request,
  input wire logic dma_request,
  output logic dma_grant,
  input wire logic config_input,
  output logic processor_clock_out
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_T1, ST_T2, ST_T3, ST_T4, ST_WAIT, ST_T5, ST_T6, ST_EXTRA
  } phase_t;

  phase_t phase;
  logic [2:0] phCnt;
  logic [5:0] elapsed;
  cfg_t cfg;
  xfer_t xfer;
  logic reqPending;
  logic swBusy;
  logic isRefresh;
  logic cfgDone;
  logic cfgStart;
  logic [CFG_BITS-1:0] cfgWord;
  logic cfgBusy;
  logic cfgLoaded;
  logic [31:0] rdata;
  logic [DIV_W-1:0] divCnt;
  logic tick;
  logic [REF_CNT_W-1:0] refCnt;
  logic [REF_ROW_W-1:0] refRow;
  logic [1:0] waitSync;
  logic [1:0] dmaSync;
  logic [1:0] cfgSync;
  logic [31:0] dataSync1;
  logic [31:0] dataSync2;
  logic wrPend;
  logic [7:0] wrAddr;
  logic lastTick;

  // number of half-cycles for the current phase, minus one
  function automatic logic [2:0] lastCount(phase_t p, cfg_t c);
    case (p)
      ST_T1: lastCount = {1'b0, c.t1Len};
      ST_T2: lastCount = {1'b0, c.t2Len};
      ST_T3: lastCount = {1'b0, c.t3Len};
      ST_T4: lastCount = {1'b0, c.t4Len};
      ST_T5: lastCount = {1'b0, c.t5Len};
      ST_T6: lastCount = c.t6Len;
      default: lastCount = 3'h0;
    endcase
  endfunction

  // output enables per bus bit from byte enables (bus bit j is data j+2)
  function automatic logic [29:0] laneMask(logic [3:0] be);
    logic [29:0] m;
    m = '0;
    for (int j = 0; j < 30; j++) begin
      m[j] = be[(j + 2) / 8];
    end
    return m;
  endfunction

  function automatic logic inRange(phase_t p, phase_t lo, phase_t hi);
    return (p >= lo) && (p <= hi);
  endfunction

  // half-cycle tick and processor clock out
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      divCnt <= '0;
      tick <= 1'b0;
      processor_clock_out <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (divCnt == DIV_W'(HALF_CYCLE_CLKS - 1)) begin
        divCnt <= '0;
        tick <= 1'b1;
      end else begin
        divCnt <= divCnt + 1'b1;
      end
      // tick pulse and clock edge coincide; half period fixed by divider
      if (tick) begin
        processor_clock_out <= !processor_clock_out; // RQ11
      end
    end
  end

  // pin synchronisers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      waitSync <= '0;
      dmaSync <= '0;
      cfgSync <= '0;
      dataSync1 <= '0;
      dataSync2 <= '0;
    end else begin
      waitSync <= {waitSync[0], wait_request};
      dmaSync <= {dmaSync[0], dma_request};
      cfgSync <= {cfgSync[0], config_input};
      dataSync1 <= {shared_addr_data_bus_in, refresh_flag_data1_in,
                    write_flag_data0_in};
      dataSync2 <= dataSync1;
    end
  end

  config_shift loader (
    .sys_clk(sys_clk),
    .srst(srst),
    .tick(tick),
    .start(cfgStart),
    .bitIn(cfgSync[1]),
    .word(cfgWord),
    .busy(cfgBusy),
    .done(cfgLoaded)
  );

  // active configuration: four half-cycles per phase until the pin load completes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg <= cfg_t'(CFG_RESET); // RQ23
      cfgDone <= 1'b0;
    end else if (cfgLoaded) begin
      cfg <= cfg_t'(cfgWord); // RQ20
      if (cfgWord[12:10] > T6_MAX_CODE) begin
        cfg.t6Len <= T6_MAX_CODE; // RQ12
      end
      cfgDone <= 1'b1;
    end
  end

  // ahb-lite slave: zero wait states, always okay
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= '0;
      wrPend <= 1'b0;
      wrAddr <= '0;
    end else begin
      wrPend <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        wrPend <= hwrite;
        wrAddr <= haddr[7:0];
        case (haddr[7:0])
          OFS_ADDR: hrdata <= xfer.addr;
          OFS_WDATA: hrdata <= xfer.wdata;
          OFS_RDATA: hrdata <= rdata;
          OFS_STATUS: begin
            hrdata <= '0;
            hrdata[ST_BUSY_BIT] <= swBusy;
            hrdata[ST_CFG_DONE_BIT] <= cfgDone;
            hrdata[ST_REF_DUE_BIT] <= refresh_due;
            hrdata[ST_GRANT_BIT] <= dma_grant;
            hrdata[ST_CFG_BUSY_BIT] <= cfgBusy;
          end
          OFS_CFG_LO: hrdata <= cfg[31:0];
          OFS_CFG_HI: hrdata <= {22'h00_0000, cfg[CFG_BITS-1:32]};
          OFS_CTRL: hrdata <= {27'h000_0000, xfer.byteEn, xfer.write};
          default: hrdata <= '0;
        endcase
      end
    end
  end

  // software transfer request and register writes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      xfer <= '0;
      reqPending <= 1'b0;
      swBusy <= 1'b0;
      cfgStart <= 1'b1;
    end else begin
      cfgStart <= 1'b0;
      if (lastTick && !isRefresh) begin
        swBusy <= 1'b0;
      end
      if (tick && phase == ST_IDLE && processor_clock_out == 1'b0 &&
          !dma_grant && reqPending && !refresh_due) begin
        reqPending <= 1'b0;
      end
      if (wrPend) begin
        case (wrAddr)
          OFS_ADDR: xfer.addr <= hwdata;
          OFS_WDATA: xfer.wdata <= hwdata;
          OFS_CTRL: begin
            if (hwdata[CTRL_START_BIT] && !swBusy) begin
              xfer.write <= hwdata[CTRL_WRITE_BIT];
              xfer.byteEn <= hwdata[CTRL_BE_LSB +: 4]; // RQ6
              reqPending <= 1'b1;
              swBusy <= 1'b1;
            end
            cfgStart <= hwdata[CTRL_RELOAD_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  // refresh interval timer; a new expiry wins over the clear at launch
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      refCnt <= '0;
      refresh_due <= 1'b0;
    end else begin
      if (phase == ST_IDLE && tick && !processor_clock_out &&
          !dma_grant && refresh_due) begin
        refresh_due <= 1'b0;
      end
      if (!cfg.refreshOn) begin
        refCnt <= '0; // RQ18
      end else if (tick) begin
        if (refCnt >= REF_CNT_W'({cfg.refInterval, 3'h0})) begin
          refCnt <= '0;
          refresh_due <= 1'b1; // RQ19
        end else begin
          refCnt <= refCnt + 1'b1;
        end
      end
    end
  end

  // dma hand-over only between cycles and only on falling clock ticks
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dma_grant <= 1'b0;
    end else if (tick && processor_clock_out) begin
      if (dmaSync[1] && phase == ST_IDLE && !dma_grant) begin
        dma_grant <= 1'b1; // RQ9 RQ10
      end else if (!dmaSync[1] && dma_grant) begin
        dma_grant <= 1'b0; // RQ10
      end
    end
  end

  assign lastTick = tick && (phase == ST_T6 || phase == ST_EXTRA) &&
                    phCnt == lastCount(phase, cfg);

  // phase sequencer, one step per half-cycle tick
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      phase <= ST_IDLE;
      phCnt <= '0;
      elapsed <= '0;
      isRefresh <= 1'b0;
      refRow <= '0;
      rdata <= '0;
    end else if (tick) begin
      if (elapsed != 6'h3f) begin
        elapsed <= elapsed + 1'b1;
      end
      phCnt <= phCnt + 1'b1;
      case (phase)
        ST_IDLE: begin
          phCnt <= '0;
          // T1 always starts at a rising processor clock edge
          if (!processor_clock_out && !dma_grant) begin
            // a due refresh is served even if refresh was switched off since
            if (refresh_due) begin
              isRefresh <= 1'b1;
              phase <= ST_T1;
            end else if (reqPending) begin
              isRefresh <= 1'b0;
              phase <= ST_T1;
            end
          end
        end
        ST_T1, ST_T2, ST_T3, ST_T5: begin
          if (phCnt == lastCount(phase, cfg)) begin
            phCnt <= '0;
            phase <= phase_t'(phase + 1'b1); // RQ21
            if (phase == ST_T1) begin
              elapsed <= '0; // RQ16
            end
            if (phase == ST_T5) begin
              phase <= ST_T6;
              if (!isRefresh && !xfer.write) begin
                rdata <= dataSync2; // RQ3 RQ2 RQ13
              end
            end
          end
        end
        ST_T4: begin
          if (phCnt == lastCount(phase, cfg)) begin
            phCnt <= '0;
            phase <= waitSync[1] ? ST_WAIT : ST_T5; // RQ8
          end
        end
        ST_WAIT: begin
          phCnt <= '0;
          // leave only so that T5 begins on a rising edge
          if (!waitSync[1] && !processor_clock_out) begin
            phase <= ST_T5; // RQ8
          end
        end
        ST_T6: begin
          if (phCnt == lastCount(phase, cfg)) begin
            phCnt <= '0;
            if (isRefresh) begin
              refRow <= refRow + 1'b1;
            end
            // a falling edge here means an odd total so far
            phase <= processor_clock_out ? ST_EXTRA : ST_IDLE; // RQ22
          end
        end
        ST_EXTRA: begin
          phCnt <= '0;
          phase <= ST_IDLE; // RQ22
        end
        default: phase <= ST_IDLE;
      endcase
    end
  end

  // pin drive, registered from the sequencer state
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      shared_addr_data_bus_out <= '0;
      shared_addr_data_bus_oe <= '0;
      write_flag_data0_out <= 1'b1;
      write_flag_data0_oe <= 1'b0;
      refresh_flag_data1_out <= 1'b1;
      refresh_flag_data1_oe <= 1'b0;
      read_strobe_n <= 1'b1;
      byte_write_strobes_n <= 4'hf;
      general_strobes_n <= 5'h1f;
      refresh_strobe_n <= 1'b1;
    end else begin
      if (phase == ST_T1 || phase == ST_T2) begin
        shared_addr_data_bus_out <= isRefresh ?
          {1'b0, REF_FILL, refRow} : xfer.addr[31:2];
        shared_addr_data_bus_oe <= '1; // RQ1
        write_flag_data0_out <= !(xfer.write && !isRefresh); // RQ4
        refresh_flag_data1_out <= !isRefresh; // RQ5
        write_flag_data0_oe <= 1'b1;
        refresh_flag_data1_oe <= 1'b1;
      end else if (phase == ST_IDLE) begin
        // the bus is released while the dma requester owns it
        shared_addr_data_bus_out <= xfer.addr[31:2];
        shared_addr_data_bus_oe <= dma_grant ? '0 : '1; // RQ9
        write_flag_data0_out <= 1'b1;
        refresh_flag_data1_out <= 1'b1;
        write_flag_data0_oe <= !dma_grant;
        refresh_flag_data1_oe <= !dma_grant;
      end else begin
        // unwritten bytes stay tristated in data phases
        shared_addr_data_bus_out <= xfer.wdata[31:2]; // RQ2
        write_flag_data0_out <= xfer.wdata[0]; // RQ4
        refresh_flag_data1_out <= xfer.wdata[1]; // RQ5
        if (xfer.write && !isRefresh) begin
          shared_addr_data_bus_oe <= laneMask(xfer.byteEn); // RQ1
          write_flag_data0_oe <= xfer.byteEn[0];
          refresh_flag_data1_oe <= xfer.byteEn[0];
        end else begin
          shared_addr_data_bus_oe <= '0;
          write_flag_data0_oe <= 1'b0;
          refresh_flag_data1_oe <= 1'b0;
        end
      end
      read_strobe_n <= !(!xfer.write && !isRefresh &&
                         inRange(phase, ST_T4, ST_T5)); // RQ3
      byte_write_strobes_n <= (xfer.write && !isRefresh &&
        inRange(phase, ST_T4, ST_T5)) ? ~xfer.byteEn : 4'hf; // RQ6
      refresh_strobe_n <= !(isRefresh && inRange(phase, ST_T1, ST_T6));
      general_strobes_n[0] <= !inRange(phase, ST_T2, ST_T5); // RQ14 RQ7
      general_strobes_n[1] <= !(inRange(phase, ST_T2, ST_T6) &&
        cfg.s1Length != 5'h00 &&
        elapsed < {1'b0, cfg.s1Length}); // RQ15 RQ16
      general_strobes_n[2] <= !(inRange(phase, ST_T2, ST_T5) &&
        cfg.s2Delay != 5'h00 && elapsed >= {1'b0, cfg.s2Delay}); // RQ17
      general_strobes_n[3] <= !(inRange(phase, ST_T2, ST_T5) &&
        cfg.s3Delay != 5'h00 && elapsed >= {1'b0, cfg.s3Delay}); // RQ17
      general_strobes_n[4] <= !(inRange(phase, ST_T2, ST_T5) &&
        cfg.s4Delay != 5'h00 && elapsed >= {1'b0, cfg.s4Delay}); // RQ17
    end
  end

endmodule

// File: shared/ext_bus_pkg.sv
// constants, field layouts and carrier types for the external bus sequencer
package ext_bus_pkg;

  // timing: half-cycle unit derived from the system clock rate
  localparam int CLK_PERIOD_NS = 10;
  localparam int HALF_CYCLE_NS = 80;
  localparam int HALF_CYCLE_CLKS =
    (HALF_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W = 8;

  // register byte offsets on the AHB-Lite port
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CFG_LO = 8'h14;
  localparam logic [7:0] OFS_CFG_HI = 8'h18;

  // control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_RELOAD_BIT = 2;
  localparam int CTRL_BE_LSB = 4;

  // status register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_CFG_DONE_BIT = 1;
  localparam int ST_REF_DUE_BIT = 2;
  localparam int ST_GRANT_BIT = 3;
  localparam int ST_CFG_BUSY_BIT = 4;

  // serial configuration word, shifted in lsb first
  localparam int CFG_BITS = 42;
  localparam int CFG_CNT_W = 6;

  typedef struct packed {
    logic [7:0] refInterval;
    logic refreshOn;
    logic [4:0] s4Delay;
    logic [4:0] s3Delay;
    logic [4:0] s2Delay;
    logic [4:0] s1Length;
    logic [2:0] t6Len;
    logic [1:0] t5Len;
    logic [1:0] t4Len;
    logic [1:0] t3Len;
    logic [1:0] t2Len;
    logic [1:0] t1Len;
  } cfg_t;

  // every phase at four half-cycles, refresh off, strobes 1-4 idle
  localparam logic [CFG_BITS-1:0] CFG_RESET = 42'h000_0000_0fff;
  localparam logic [2:0] T6_MAX_CODE = 3'h4;
  localparam int REF_UNIT_SHIFT = 3;
  localparam int REF_CNT_W = 12;

  // refresh address layout on the 30-bit shared bus
  localparam int REF_ROW_W = 10;
  localparam logic [18:0] REF_FILL = 19'h7_ffff;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic write;
    logic [3:0] byteEn;
  } xfer_t;

endpackage

// File: src/config_shift.sv
// serial loader for the interface timing configuration word
`timescale 1ns/100ps
module config_shift
  import ext_bus_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic tick,
  input wire logic start,
  input wire logic bitIn,
  output logic [CFG_BITS-1:0] word,
  output logic busy,
  output logic done
);

  logic [CFG_CNT_W-1:0] count;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      word <= '0;
      busy <= 1'b0;
      count <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        count <= '0;
      end else if (busy && tick) begin
        word <= {bitIn, word[CFG_BITS-1:1]};
        if (count == CFG_CNT_W'(CFG_BITS - 1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule

// File: sim/ext_bus_checker.sv
// port assertions for the external memory bus sequencer
`timescale 1ns/100ps
module ext_bus_checker
  import ext_bus_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [29:0] shared_addr_data_bus_oe,
  input wire logic write_flag_data0_oe,
  input wire logic read_strobe_n,
  input wire logic [3:0] byte_write_strobes_n,
  input wire logic [4:0] general_strobes_n,
  input wire logic refresh_strobe_n,
  input wire logic refresh_due,
  input wire logic dma_grant,
  input wire logic processor_clock_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_hi8; processor_clock_out [*8]; endsequence
  sequence s_lo8; !processor_clock_out [*8]; endsequence
  property p_clk_hi;
    $rose(processor_clock_out) |-> s_hi8 ##1 !processor_clock_out;
  endproperty
  property p_clk_lo;
    $fell(processor_clock_out) |-> s_lo8 ##1 processor_clock_out;
  endproperty
  property p_okay; hreadyout && !hresp; endproperty
  property p_rd_bus; !read_strobe_n |-> shared_addr_data_bus_oe == '0;
  endproperty
  property p_rd_end; $rose(read_strobe_n) |-> $rose(general_strobes_n[0]);
  endproperty
  property p_s0_span; !read_strobe_n |-> !general_strobes_n[0]; endproperty
  property p_late; !(&general_strobes_n[4:2]) |-> !general_strobes_n[0];
  endproperty
  property p_excl; !read_strobe_n |-> &byte_write_strobes_n; endproperty
  property p_grant_edge; $changed(dma_grant) |-> !processor_clock_out;
  endproperty
  property p_grant_bus; dma_grant && $past(dma_grant) |->
    shared_addr_data_bus_oe == '0 && !write_flag_data0_oe;
  endproperty
  property p_ref_due; $fell(refresh_due) |-> ##[0:2] !refresh_strobe_n;
  endproperty
  a_clk_hi: assert property (p_clk_hi)
    else $error("clock out high phase wrong");
  a_clk_lo: assert property (p_clk_lo)
    else $error("clock out low phase wrong");
  a_okay: assert property (p_okay)
    else $error("bus slave not ready or not okay");
  a_rd_bus: assert property (p_rd_bus)
    else $error("bus driven during read strobe");
  a_rd_end: assert property (p_rd_end)
    else $error("read strobe end not with strobe 0 end");
  a_s0_span: assert property (p_s0_span)
    else $error("read strobe outside strobe 0");
  a_late: assert property (p_late)
    else $error("delayed strobe outside strobe 0");
  a_excl: assert property (p_excl)
    else $error("read and write strobes together");
  a_grant_edge: assert property (p_grant_edge)
    else $error("grant changed off falling edge");
  a_grant_bus: assert property (p_grant_bus)
    else $error("bus driven while granted");
  a_ref_due: assert property (p_ref_due)
    else $error("refresh due dropped without refresh cycle");
endmodule

bind ext_memory_bus_sequencer ext_bus_checker chk (.sys_clk, .srst,
  .hreadyout, .hresp, .shared_addr_data_bus_oe, .write_flag_data0_oe,
  .read_strobe_n, .byte_write_strobes_n, .general_strobes_n,
  .refresh_strobe_n, .refresh_due, .dma_grant, .processor_clock_out);

// File: sim/mem_partner.sv
// behavioural memory on the far side of the multiplexed bus
`timescale 1ns/100ps
module mem_partner
  import ext_bus_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [31:0] busWire,
  input wire logic read_strobe_n,
  input wire logic [3:0] byte_write_strobes_n,
  input wire logic s0n,
  input wire logic slow,
  output logic [31:0] drive,
  output logic wait_request
);
  logic [31:0] mem [16];
  logic [3:0] idx = '0;
  logic [3:0] bwPrev = 4'hf;
  logic wrCyc = 1'b0;
  logic s0Prev = 1'b1;
  int s0Cnt = 0;
  initial begin
    foreach (mem[i]) mem[i] = 32'h0000_0000;
    drive = 32'h0000_0000;
  end
  // fixed span from strobe 0 so a slow cycle still ends
  assign wait_request = slow && !s0n && s0Cnt < 80;
  always @(posedge sys_clk) begin
    s0Prev <= s0n;
    bwPrev <= byte_write_strobes_n;
    s0Cnt <= s0n ? 0 : s0Cnt + 1;
    if (s0Prev && !s0n) begin
      idx <= busWire[5:2];
      wrCyc <= !busWire[0];
    end
    for (int b = 0; b < 4; b++)
      if (wrCyc && !bwPrev[b] && byte_write_strobes_n[b])
        mem[idx][8*b +: 8] <= busWire[8*b +: 8];
    // released bus shows the inverse of its last level
    drive <= (!wrCyc && !read_strobe_n) ? mem[idx] : ~busWire;
  end
endmodule

// File: sim/ext_memory_bus_sequencer_bench.sv
// self-checking bench for the external memory bus sequencer
`timescale 1ns/100ps
module ext_memory_bus_sequencer_bench
  import ext_bus_pkg::*;
;
  typedef struct {logic [31:0] a, d, e; logic [3:0] be;} row_t;
  row_t rows [5] = '{
    '{32'h0000_0010, 32'h1234_5678, 32'h1234_5678, 4'hf},
    '{32'h0000_0014, 32'hffff_ffff, 32'h0000_00ff, 4'h1},
    '{32'h0000_0018, 32'haaaa_5555, 32'haa00_0000, 4'h8},
    '{32'h0000_001c, 32'h0000_0003, 32'h0000_0003, 4'hf},
    '{32'h0000_0020, 32'h8765_4321, 32'h0065_4300, 4'h6}};
  logic sys_clk = 0, srst = 1, hwrite = 0, dma_request = 0;
  logic slow = 0, clr = 0, cfgRst = 0, pcoSeen = 0, cfgPin;
  logic [1:0] htrans = '0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, drive, r, busWire;
  logic hreadyout, hresp, write_flag_data0_out, write_flag_data0_oe;
  logic refresh_flag_data1_out, refresh_flag_data1_oe, read_strobe_n;
  logic refresh_strobe_n, refresh_due, dma_grant, processor_clock_out;
  logic wait_request;
  logic [29:0] shared_addr_data_bus_out, shared_addr_data_bus_oe;
  logic [3:0] byte_write_strobes_n;
  logic [4:0] general_strobes_n;
  logic [6:0] act;
  int num_errors = 0, total_checks = 0, n, tog = 0;
  int lowCnt [7];
  cfg_t cfg;

  assign busWire[31:2] = (shared_addr_data_bus_out & shared_addr_data_bus_oe)
    | (drive[31:2] & ~shared_addr_data_bus_oe);
  assign busWire[1] = refresh_flag_data1_oe ? refresh_flag_data1_out : drive[1];
  assign busWire[0] = write_flag_data0_oe ? write_flag_data0_out : drive[0];
  assign act = ~{byte_write_strobes_n[0], read_strobe_n, general_strobes_n};
  // serial config: one bit per clock-out edge, lsb first, from load start
  assign cfgPin = tog < CFG_BITS ? cfg[tog] : 1'b0;

  ext_memory_bus_sequencer uut (.sys_clk, .srst, .hsel(1'b1), .haddr,
    .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .shared_addr_data_bus_in(busWire[31:2]),
    .shared_addr_data_bus_out, .shared_addr_data_bus_oe,
    .write_flag_data0_in(busWire[0]), .write_flag_data0_out,
    .write_flag_data0_oe, .refresh_flag_data1_in(busWire[1]),
    .refresh_flag_data1_out, .refresh_flag_data1_oe, .read_strobe_n,
    .byte_write_strobes_n, .general_strobes_n, .refresh_strobe_n,
    .refresh_due, .wait_request, .dma_request, .dma_grant,
    .config_input(cfgPin), .processor_clock_out);
  mem_partner mp (.sys_clk, .busWire, .read_strobe_n, .byte_write_strobes_n,
    .s0n(general_strobes_n[0]), .slow, .drive, .wait_request);

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    foreach (lowCnt[i]) lowCnt[i] <= clr ? 0 : lowCnt[i] + act[i];
  always @(posedge sys_clk) begin
    pcoSeen <= processor_clock_out;
    tog <= (srst || cfgRst) ? 0 : tog + (processor_clock_out != pcoSeen);
  end

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task memop(input logic w, input logic [31:0] a, input logic [31:0] d,
    input logic [3:0] be);
    clr <= 1;
    @(posedge sys_clk);
    clr <= 0;
    ahb(1, OFS_ADDR, a);
    ahb(1, OFS_WDATA, d);
    ahb(1, OFS_CTRL, {24'h00_0000, be, 2'b00, w, 1'b1});
    for (n = 0; n < 500 && general_strobes_n[0] !== 1'b0; n++)
      @(posedge sys_clk);
    n = 0;
    do begin
      ahb(0, OFS_STATUS, 0);
      n++;
    end while (r[ST_BUSY_BIT] !== 1'b0 && n < 200);
  endtask
  task results;
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    cfg = '0;
    cfg.s1Length = 5'h3;
    cfg.s2Delay = 5'h2;
    cfg.s3Delay = 5'h1f;
    cfg.t6Len = 3'h1;
    repeat (10) @(posedge sys_clk);
    srst <= 0;
    memop(0, 32'h0000_0040, 0, 4'h0);
    chk("read low at reset", 64, lowCnt[5]);
    chk("s0 low at reset", 128, lowCnt[0]);
    n = 0;
    do begin
      ahb(0, OFS_STATUS, 0);
      n++;
    end while (r[ST_CFG_DONE_BIT] !== 1'b1 && n < 400);
    chk("config done", 1, r[ST_CFG_DONE_BIT]);
    ahb(0, OFS_CFG_LO, 0);
    chk("config low", cfg[31:0], r);
    ahb(0, 8'h20, 0);
    chk("unmapped", 0, r);
    foreach (rows[i]) begin
      memop(1, rows[i].a, rows[i].d, rows[i].be);
      chk("write strobe 0 low", rows[i].be[0] ? 16 : 0, lowCnt[6]);
      memop(0, rows[i].a, 0, 4'h0);
      ahb(0, OFS_RDATA, 0);
      chk("read data", rows[i].e, r);
      chk("read low", 16, lowCnt[5]);
      chk("s0 low", 32, lowCnt[0]);
      chk("s1 low", 24, lowCnt[1]);
      chk("s2 low", 16, lowCnt[2]);
      chk("s3 s4 low", 0, lowCnt[3] + lowCnt[4]);
    end
    slow <= 1;
    memop(0, rows[0].a, 0, 4'h0);
    slow <= 0;
    chk("waits added", 1, lowCnt[5] > 16);
    chk("s1 with waits", 24, lowCnt[1]);
    chk("s0 with waits", lowCnt[5] + 16, lowCnt[0]);
    chk("s2 with waits", lowCnt[0] - 16, lowCnt[2]);
    ahb(1, OFS_RDATA, 32'h5a5a_5a5a);
    ahb(0, OFS_RDATA, 0);
    chk("read data after waits", rows[0].e, r);
    dma_request <= 1;
    for (n = 0; n < 100 && dma_grant !== 1'b1; n++) @(posedge sys_clk);
    @(posedge sys_clk);
    chk("bus enables granted", 0, {shared_addr_data_bus_oe,
      write_flag_data0_oe, refresh_flag_data1_oe});
    ahb(0, OFS_STATUS, 0);
    chk("grant status", 1, r[ST_GRANT_BIT]);
    dma_request <= 0;
    for (n = 0; n < 100 && dma_grant !== 1'b0; n++) @(posedge sys_clk);
    chk("grant released", 0, dma_grant);
    cfg.refreshOn = 1'b1;
    cfg.refInterval = 8'h01;
    cfgRst <= 1;
    ahb(1, OFS_CTRL, 32'h0000_0004);
    // hold the bit count until the loader has taken its start
    repeat (2) @(posedge sys_clk);
    cfgRst <= 0;
    for (n = 0; n < 1000 && refresh_strobe_n !== 1'b0; n++)
      @(posedge sys_clk);
    @(posedge sys_clk);
    chk("refresh address", {1'b0, REF_FILL},
      shared_addr_data_bus_out[29:10]);
    chk("refresh flag", 0, refresh_flag_data1_out);
    srst <= 1;
    repeat (3) @(posedge sys_clk);
    chk("pins in reset", {2'b11, 4'hf, 5'h1f, 2'b00}, {read_strobe_n,
      refresh_strobe_n, byte_write_strobes_n, general_strobes_n,
      refresh_due, dma_grant});
    srst <= 0;
    repeat (2) @(posedge sys_clk);
    results;
  end
  initial begin
    #100000;
    num_errors++;
    results;
  end
endmodule
